// *** rtl/acc_pkg.sv ***
package acc_pkg;

	// Control register field positions
	localparam int unsigned CTRL_SEL_LSB = 0;
	localparam int unsigned CTRL_SEL_MSB = 2;
	localparam int unsigned CTRL_START_BIT = 3;
	localparam int unsigned CTRL_DONE_BIT = 4;
	localparam int unsigned CTRL_POWER_BIT = 5;

	// Reset values
	localparam logic [2:0] CHAN_SEL_RST = 3'h0;
	localparam logic [6:0] PRESCALE_RST = 7'h00;

	// Channel count and code range
	localparam int unsigned NUM_CHAN = 6;
	localparam int unsigned RES_BITS = 10;
	localparam logic [9:0] CODE_FULL = 10'h3ff;
	localparam logic [9:0] CODE_ZERO = 10'h000;

	// Base divider: period is BASE_DIV_TOP minus twice the reload value
	localparam logic [5:0] BASE_DIV_TOP = 6'h20;
	// Prescaler period when the prescale field is zero
	localparam logic [8:0] PRS_ZERO_DIV = 9'h100;

	// Conversion length in conversion clock ticks: one sample, ten bits
	localparam logic [3:0] CONV_TICKS = 4'hb;

	// Conversion sequencer states
	typedef enum logic [0:0] {
		ACC_IDLE = 1'b0,
		ACC_CONV = 1'b1
	} acc_state_t;

endpackage

// *** rtl/acc_clkdiv.sv ***
`timescale 1ns/1ns
`default_nettype none
// Two-stage divider producing a one-cycle conversion clock tick.
// The tick is an enable pulse on i_clk_sys, not a separate clock, so the
// whole block stays in one domain.
module acc_clkdiv
(
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	// Configuration
	input wire logic i_double_speed,
	input wire logic [3:0] i_osc_reload,
	input wire logic [6:0] i_prescale,
	// Restart aligns the tick to the start of a conversion
	input wire logic i_restart,
	// Conversion clock tick
	output logic o_tick
);

	logic [5:0] base_cnt_r;
	logic [5:0] base_term;
	logic base_en;
	logic [8:0] prs_cnt_r;
	logic [8:0] prs_term;

	assign base_term = acc_pkg::BASE_DIV_TOP - {1'b0, i_osc_reload, 1'b0};
	// Double speed bypasses the first stage
	assign base_en = i_double_speed ? 1'b1 : (base_cnt_r == base_term - 6'h01);

	// First stage counter
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rstn || i_restart || base_en)
			base_cnt_r <= 6'h00;
		else
			base_cnt_r <= base_cnt_r + 6'h01;
	end

	// Prescale ratio, 256 when field is zero
	assign prs_term = (i_prescale == 7'h00) ? acc_pkg::PRS_ZERO_DIV :
		{1'b0, i_prescale, 1'b0};

	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rstn || i_restart)
			prs_cnt_r <= 9'h000;
		else if (base_en)
			prs_cnt_r <= (prs_cnt_r == prs_term - 9'h001) ? 9'h000 :
				prs_cnt_r + 9'h001;
	end

	// Combinational handshake-style pulse
	assign o_tick = !i_restart && base_en && (prs_cnt_r == prs_term - 9'h001);

endmodule
`default_nettype wire

// *** rtl/acc_input_map.sv ***
`timescale 1ns/1ns
`default_nettype none
// Channel multiplexer and saturating code mapping.
// Each level is signed, scaled so ground is 0 and the reference is 3ffh.
module acc_input_map
(
	// Channel select
	input wire logic [2:0] i_chan_sel,
	// Levels of the six inputs, already relative to analog ground
	input wire logic [12*6-1:0] i_ain_level,
	// One-hot selected input, zero for unassigned codes
	output logic [5:0] o_chan_onehot,
	// Clamped code of the selected input
	output logic [9:0] o_code
);

	logic signed [11:0] sel_level;

	// Binary decode, codes six and seven pick nothing
	genvar gi;
	generate
		for (gi = 0; gi < acc_pkg::NUM_CHAN; gi++)
		begin : g_sel
			assign o_chan_onehot[gi] = (i_chan_sel == 3'(gi));
		end
	endgenerate

	// Mux of the selected level; no input reads as ground
	always_comb
	begin
		sel_level = 12'sh000;
		if (i_chan_sel < 3'h6)
			sel_level = i_ain_level[12*i_chan_sel +: 12];
	end

	always_comb
	begin
		if (sel_level < 12'sh000)
			o_code = acc_pkg::CODE_ZERO;
		else if (sel_level > 12'sh3ff)
			o_code = acc_pkg::CODE_FULL;
		else
			o_code = sel_level[9:0];
	end

endmodule
`default_nettype wire

// *** rtl/acc_conv_ctrl.sv ***
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Writing start bit begins one conversion
// - Start bit reads busy, hardware clears
// - Start writes ignored while converting
// - Done flag sets with result, software clears
// - Interrupt when done and enable set
// - Select codes 0-5 pick inputs, 6-7 none
// - Reference gives 3ffh, ground 000h, linear
// - Out-of-range inputs saturate to limits
// - Seven-bit prescaler makes the conversion clock
// - Base clock is oscillator over 32-2*reload, undivided in double speed
// - Clearing power bit puts converter in standby
module acc_conv_ctrl
(
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rstn,

	// Control register write port
	input wire logic i_ctrl_wr,
	input wire logic [7:0] i_ctrl_wdata,
	// Control register read value
	output logic [7:0] o_ctrl_rdata,

	// Converter clock register write port
	input wire logic i_clkreg_wr,
	input wire logic [7:0] i_clkreg_wdata,
	output logic [7:0] o_clkreg_rdata,

	// System configuration bits
	input wire logic i_double_speed,
	input wire logic [3:0] i_osc_reload,
	input wire logic i_conv_irq_enable,

	// Analog front end, sampled levels synchronous to i_clk_sys
	input wire logic [12*6-1:0] i_ain_level,
	output logic [5:0] o_selected_analog_input,

	// Results and status
	output logic [7:0] o_result_high,
	output logic [7:0] o_result_low,
	output logic o_conv_busy,
	output logic o_conv_irq
);

	// Sequencer state register
	acc_pkg::acc_state_t state_r;
	acc_pkg::acc_state_t state_nxt;

	// Stored configuration and status
	logic [2:0] chan_sel_r;
	logic power_on_r;
	logic done_r;
	logic irq_r;
	logic [6:0] prescale_r;

	// Successive approximation datapath
	logic [3:0] tick_cnt_r;
	logic [9:0] sample_r;
	logic [9:0] sar_r;
	logic [9:0] mask_r;
	logic [9:0] trial;
	logic [9:0] code;
	logic [9:0] result_final;

	// Result registers
	logic [7:0] res_high_r;
	logic [1:0] res_low_r;

	// Internal strobes
	logic tick;
	logic start_req;
	logic finish;
	logic abort;
	logic sample_tick;
	logic decide;

	// Conversion timeline, counted in conversion clock ticks:
	// start edge: busy rises and the divider restarts, so no partial period
	// tick 1: the mapped level is captured into sample_r
	// ticks 2 to 11: one result bit per tick, MSB first
	// tick 11: results load, done sets and busy drops on one edge
	// next cycle: the interrupt request follows done when enabled
	// A conversion therefore lasts exactly eleven tick periods.

	// Converter clock generation
	acc_clkdiv u_clkdiv
	(
		.i_clk_sys(i_clk_sys),
		.i_rstn(i_rstn),
		.i_double_speed(i_double_speed),
		.i_osc_reload(i_osc_reload),
		.i_prescale(prescale_r),
		.i_restart(start_req),
		.o_tick(tick)
	);

	// Input selection and saturation
	acc_input_map u_map
	(
		.i_chan_sel(chan_sel_r),
		.i_ain_level(i_ain_level),
		.o_chan_onehot(o_selected_analog_input),
		.o_code(code)
	);

	// Start request from a write of one
	// Busy state masks the start bit
	// No start while in standby
	// The power bit tested is the stored one, so a single write that
	// powers up and starts together is refused; power up first.
	assign start_req = i_ctrl_wr && i_ctrl_wdata[acc_pkg::CTRL_START_BIT] &&
		(state_r == acc_pkg::ACC_IDLE) && power_on_r;

	// Last of eleven ticks ends the conversion
	// Busy and done change on this one edge, never a cycle apart
	assign finish = (state_r == acc_pkg::ACC_CONV) && tick &&
		(tick_cnt_r == acc_pkg::CONV_TICKS - 4'h1);

	// Dropping power aborts a running conversion
	// Results and done stay as they were unless finish falls in the same cycle; otherwise the partial code is discarded
	assign abort = (state_r == acc_pkg::ACC_CONV) && !power_on_r;

	// Sequencer next state
	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			acc_pkg::ACC_IDLE:
			begin
				if (start_req)
					state_nxt = acc_pkg::ACC_CONV;
			end
			acc_pkg::ACC_CONV:
			begin
				if (finish || abort)
					state_nxt = acc_pkg::ACC_IDLE;
			end
		endcase
	end

	// Sequencer state
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rstn)
			state_r <= acc_pkg::ACC_IDLE;
		else
			state_r <= state_nxt;
	end

	// Channel select; writable any time, even mid-conversion, because
	// the level is captured on the first tick and held from then on
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rstn)
			chan_sel_r <= acc_pkg::CHAN_SEL_RST;
		else if (i_ctrl_wr)
			chan_sel_r <= i_ctrl_wdata[acc_pkg::CTRL_SEL_MSB:
				acc_pkg::CTRL_SEL_LSB];
	end

	// Power bit
	// Cleared mid-conversion it aborts the run; software should still
	// let a conversion end before any power reduction
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rstn)
			power_on_r <= 1'b0;
		else if (i_ctrl_wr)
			power_on_r <= i_ctrl_wdata[acc_pkg::CTRL_POWER_BIT];
	end

	// Prescale field of the converter clock register
	// A change takes effect at once and retimes a running conversion
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rstn)
			prescale_r <= acc_pkg::PRESCALE_RST;
		else if (i_clkreg_wr)
			prescale_r <= i_clkreg_wdata[6:0];
	end

	// Tick counter within a conversion
	// Cleared by the start strobe so every run counts from zero
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rstn || start_req)
			tick_cnt_r <= 4'h0;
		else if (state_r == acc_pkg::ACC_CONV && tick)
			tick_cnt_r <= tick_cnt_r + 4'h1;
	end

	// Trial value for the current bit decision
	assign trial = sar_r | mask_r;

	// First tick samples, each later tick decides one bit
	assign sample_tick = (state_r == acc_pkg::ACC_CONV) && tick &&
		(tick_cnt_r == 4'h0);
	assign decide = (state_r == acc_pkg::ACC_CONV) && tick &&
		(tick_cnt_r != 4'h0);

	// Capture the mapped level on the first tick; holding it keeps
	// the code stable if the select changes during the run
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rstn)
			sample_r <= acc_pkg::CODE_ZERO;
		else if (sample_tick)
			sample_r <= code;
	end

	// Saved bits: a trial bit is kept when it does not overshoot
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rstn || start_req)
			sar_r <= acc_pkg::CODE_ZERO;
		else if (decide && (trial <= sample_r))
			sar_r <= trial;
	end

	// Trial bit walks down from the MSB, one place per decision
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rstn)
			mask_r <= 10'h000;
		else if (start_req)
			mask_r <= 10'h200;
		else if (decide)
			mask_r <= {1'b0, mask_r[9:1]};
	end

	// Final code folds in the last decision, so the result registers
	// load on the same edge that busy drops
	assign result_final = (trial <= sample_r) ? trial : sar_r;

	// Result registers load only on completion
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rstn)
		begin
			res_high_r <= 8'h00;
			res_low_r <= 2'h0;
		end
		else if (finish)
		begin
			// Split upper eight and lowest two
			res_high_r <= result_final[9:2];
			res_low_r <= result_final[1:0];
		end
	end

	// Done flag: set wins over a clearing write
	// A write of one to the done bit has no effect
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rstn)
			done_r <= 1'b0;
		// Set with the result, cleared by write
		else if (finish)
			done_r <= 1'b1;
		else if (i_ctrl_wr && !i_ctrl_wdata[acc_pkg::CTRL_DONE_BIT])
			done_r <= 1'b0;
	end

	// Interrupt request, registered; a level held while done and the enable are both set
	// Registered so the request cannot glitch, at one cycle of latency
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rstn)
			irq_r <= 1'b0;
		else
			irq_r <= done_r && i_conv_irq_enable;
	end

	// Register read values, reserved bits read zero
	// Combinational so software sees busy drop on the finish edge
	always_comb
	begin
		o_ctrl_rdata = 8'h00;
		o_ctrl_rdata[acc_pkg::CTRL_SEL_MSB:acc_pkg::CTRL_SEL_LSB] = chan_sel_r;
		o_ctrl_rdata[acc_pkg::CTRL_START_BIT] = (state_r == acc_pkg::ACC_CONV);
		o_ctrl_rdata[acc_pkg::CTRL_DONE_BIT] = done_r;
		o_ctrl_rdata[acc_pkg::CTRL_POWER_BIT] = power_on_r;
	end

	// Outputs straight from registers or state
	assign o_clkreg_rdata = {1'b0, prescale_r};
	assign o_result_high = res_high_r;
	assign o_result_low = {6'h00, res_low_r};
	assign o_conv_busy = (state_r == acc_pkg::ACC_CONV);
	assign o_conv_irq = irq_r;

endmodule
`default_nettype wire

// *** verif/acc_conv_ctrl_asserts.sv ***
`timescale 1ns/1ns
`default_nettype none
// Port-level checker for the conversion control block
module acc_conv_ctrl_asserts
(
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	// Register ports
	input wire logic i_ctrl_wr,
	input wire logic [7:0] i_ctrl_wdata,
	input wire logic [7:0] o_ctrl_rdata,
	input wire logic i_clkreg_wr,
	input wire logic [7:0] i_clkreg_wdata,
	input wire logic [7:0] o_clkreg_rdata,
	input wire logic i_conv_irq_enable,
	// Results and status
	input wire logic [5:0] o_selected_analog_input,
	input wire logic [7:0] o_result_high,
	input wire logic [7:0] o_result_low,
	input wire logic o_conv_busy,
	input wire logic o_conv_irq
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rstn);

	// Status, interrupt, result, selection and readback relations
	AST_START: assert property (i_ctrl_wr && i_ctrl_wdata[3] && o_ctrl_rdata[5] && !o_conv_busy |=> o_conv_busy)
		else $error("start did not raise busy");
	AST_DONE_ON_END: assert property ($fell(o_conv_busy) && o_ctrl_rdata[5] |-> o_ctrl_rdata[4])
		else $error("busy fell without done");
	AST_DONE_SRC: assert property ($rose(o_ctrl_rdata[4]) |-> $fell(o_conv_busy))
		else $error("done set outside a finish");
	AST_IRQ: assert property (1'b1 |=> o_conv_irq == $past(o_ctrl_rdata[4] && i_conv_irq_enable))
		else $error("irq does not follow done and enable");
	AST_CHAN: assert property (o_selected_analog_input == (o_ctrl_rdata[2:0] < 3'h6 ? 6'h01 << o_ctrl_rdata[2:0] : 6'h00))
		else $error("wrong input selected");
	AST_RES_LOAD: assert property (!$stable({o_result_high, o_result_low}) |-> $fell(o_conv_busy))
		else $error("result changed outside a finish");
	AST_LOW: assert property (o_result_low[7:2] == 6'h00)
		else $error("low result upper bits set");
	AST_STANDBY: assert property (!o_ctrl_rdata[5] |=> !o_conv_busy)
		else $error("busy while powered off");
	AST_CLKREG: assert property (i_clkreg_wr |=> o_clkreg_rdata == {1'b0, $past(i_clkreg_wdata[6:0])})
		else $error("prescale readback wrong");

	// Main scenarios reached
	cover property ($fell(o_conv_busy));
	cover property ($rose(o_conv_irq));
	cover property (i_clkreg_wr);
	cover property ($fell(o_conv_busy) && !o_ctrl_rdata[4]);
endmodule

bind acc_conv_ctrl acc_conv_ctrl_asserts chk_u (.i_clk_sys, .i_rstn,
	.i_ctrl_wr, .i_ctrl_wdata, .o_ctrl_rdata, .i_clkreg_wr, .i_clkreg_wdata,
	.o_clkreg_rdata, .i_conv_irq_enable, .o_selected_analog_input,
	.o_result_high, .o_result_low, .o_conv_busy, .o_conv_irq);
`default_nettype wire

// *** verif/acc_core_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// Processor core side: one-cycle register writes
module acc_core_model
(
	// Clock
	input wire logic i_clk_sys,
	// Register write strobes and data
	output logic o_ctrl_wr,
	output logic [7:0] o_ctrl_wdata,
	output logic o_clkreg_wr,
	output logic [7:0] o_clkreg_wdata
);
	initial
	begin
		o_ctrl_wr = 1'b0;
		o_clkreg_wr = 1'b0;
		o_ctrl_wdata = 8'h00;
		o_clkreg_wdata = 8'h00;
	end

	// Data is scrambled after the strobe so stale values are never trusted
	task wr(input logic clk_reg, input logic [7:0] d);
		@(negedge i_clk_sys);
		o_clkreg_wr = clk_reg;
		o_ctrl_wr = !clk_reg;
		o_clkreg_wdata = d;
		o_ctrl_wdata = d;
		@(negedge i_clk_sys);
		o_ctrl_wr = 1'b0;
		o_clkreg_wr = 1'b0;
		o_ctrl_wdata = ~d;
		o_clkreg_wdata = ~d;
	endtask

	// Clear done only after service, never power down while busy
	task service(input logic [7:0] ctrl);
		wr(1'b0, ctrl & 8'hef);
	endtask
endmodule
`default_nettype wire

// *** verif/acc_conv_ctrl_test.sv ***
`timescale 1ns/1ns
`default_nettype none
// Self-checking bench for the conversion control block
module acc_conv_ctrl_test;
	logic i_clk_sys = 1'b0;
	logic i_rstn = 1'b0;
	logic dbl = 1'b1;
	logic [3:0] reload = 4'hf;
	logic irq_en = 1'b0;
	logic [71:0] ain = {12'h155, 12'h001, 12'h500, 12'hffb, 12'h3ff, 12'h200};
	logic [9:0] exp_code [8] = '{10'h200, 10'h3ff, 10'h000, 10'h3ff,
		10'h001, 10'h155, 10'h000, 10'h000};
	logic ctrl_wr, clk_wr;
	logic [7:0] ctrl_d, clk_d, ctrl_q, clk_q, res_h, res_l;
	logic [5:0] sel_oh;
	logic o_conv_busy, o_conv_irq;
	int errors = 0;
	int n_compared = 0;

	// 100 MHz clock
	always #5 i_clk_sys = ~i_clk_sys;

	acc_core_model core_u (.i_clk_sys(i_clk_sys), .o_ctrl_wr(ctrl_wr),
		.o_ctrl_wdata(ctrl_d), .o_clkreg_wr(clk_wr), .o_clkreg_wdata(clk_d));

	acc_conv_ctrl dut_u (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
		.i_ctrl_wr(ctrl_wr), .i_ctrl_wdata(ctrl_d), .o_ctrl_rdata(ctrl_q),
		.i_clkreg_wr(clk_wr), .i_clkreg_wdata(clk_d), .o_clkreg_rdata(clk_q),
		.i_double_speed(dbl), .i_osc_reload(reload),
		.i_conv_irq_enable(irq_en), .i_ain_level(ain),
		.o_selected_analog_input(sel_oh), .o_result_high(res_h),
		.o_result_low(res_l), .o_conv_busy(o_conv_busy),
		.o_conv_irq(o_conv_irq));

	// Value comparison
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task results;
		$display("compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// One conversion; a repeated start while busy must not stretch it
	task conv(input logic [2:0] sel, input logic [9:0] code, input int cyc,
		input logic again);
		int n;
		logic [15:0] want;
		n = 0;
		core_u.wr(1'b0, 8'h28 | sel);
		if (again)
		begin
			core_u.wr(1'b0, 8'h28 | sel);
			n = 2;
		end
		while (o_conv_busy === 1'b1 && n < 5000)
		begin
			n++;
			@(negedge i_clk_sys);
		end
		chk(16'(n), 16'(cyc));
		chk(16'(ctrl_q[4]), 16'h0001);
		want = {code[9:2], 6'h00, code[1:0]};
		chk({res_h, res_l}, want);
		want = (sel < 3'h6) ? 16'h0001 << sel : 16'h0000;
		chk(16'(sel_oh), want);
		@(negedge i_clk_sys);
		chk(16'(o_conv_irq), 16'(irq_en));
		core_u.service(8'h20 | sel);
		@(negedge i_clk_sys);
		chk(16'({ctrl_q[4], o_conv_irq}), 16'h0000);
		$display("test done: channel %0d", sel);
	endtask

	initial
	begin
		repeat (10) @(negedge i_clk_sys);
		i_rstn = 1'b1;
		chk(16'({ctrl_q, sel_oh}), 16'h0001);
		core_u.wr(1'b1, 8'h81);
		chk(16'(clk_q), 16'h0001);
		core_u.wr(1'b0, 8'h08);
		chk(16'(o_conv_busy), 16'h0000);
		core_u.wr(1'b0, 8'h20);
		for (int k = 0; k < 8; k++)
		begin
			irq_en = k[0];
			conv(k[2:0], exp_code[k], 22, k == 0);
		end
		// Power dropped mid-conversion: no done, results kept
		core_u.wr(1'b0, 8'h29);
		core_u.wr(1'b0, 8'h01);
		repeat (30) @(negedge i_clk_sys);
		chk(16'({o_conv_busy, ctrl_q}), 16'h0001);
		chk({res_h, res_l}, 16'h0000);
		$display("test done: abort");
		// Reset after a start refused in standby (power bit still clear) returns every output to reset values
		core_u.wr(1'b0, 8'h2d);
		i_rstn = 1'b0;
		repeat (2) @(negedge i_clk_sys);
		i_rstn = 1'b1;
		chk({ctrl_q, clk_q}, 16'h0000);
		chk(16'({o_conv_busy, o_conv_irq, res_l}), 16'h0000);
		chk(16'({sel_oh, res_h}), 16'h0100);
		core_u.wr(1'b1, 8'h81);
		core_u.wr(1'b0, 8'h20);
		$display("test done: reset");
		dbl = 1'b0;
		conv(3'h0, 10'h200, 44, 1'b0);
		reload = 4'he;
		conv(3'h0, 10'h200, 88, 1'b0);
		dbl = 1'b1;
		core_u.wr(1'b1, 8'h00);
		conv(3'h0, 10'h200, 2816, 1'b0);
		results;
	end

	// Whole run is under 5000 cycles; allow four times that
	initial
	begin
		#200000;
		errors++;
		results;
	end
endmodule
`default_nettype wire
